// ==== hw/lss_pkg.sv ====
// Package for the LED sink shift and latch core
package lss_pkg;
  localparam int LSS_CHANNELS = 16;
  localparam logic [15:0] LSS_SHIFT_RESET = 16'h0000;
  localparam logic [15:0] LSS_LATCH_RESET = 16'h0000;
  localparam logic [15:0] LSS_CHANNELS_OFF = 16'h0000;
  localparam int LSS_LAST_STAGE = 15;
  localparam int LSS_BUF_DEPTH = 2;
  localparam logic [1:0] LSS_BUF_EMPTY = 2'h0;
endpackage : lss_pkg

// ==== hw/lss_core.sv ====
// LED sink driver core: serial shift chain, storage latch, output blanking
`timescale 1ns/1ns
module lss_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_in_pin_i,
  input wire logic serial_valid_i,
  output logic serial_ready_o,
  input wire logic latch_load_strobe_i,
  input wire logic output_blank_n_i,
  output logic [lss_pkg::LSS_CHANNELS-1:0] sink_channel_n_o,
  output logic serial_out_pin_o,
  output logic serial_out_valid_o,
  input wire logic serial_out_ready_i
);
  import lss_pkg::*;

  typedef struct packed {
    logic [LSS_CHANNELS-1:0] shift;
    logic [1:0] buf_cnt;
    logic [1:0] buf_bits;
  } lss_state_s;

  lss_state_s state_reg;
  lss_state_s state_next;
  logic [LSS_CHANNELS-1:0] latch_q;
  logic shift_en;

  // Two-entry buffer for the cascade output: a stalled downstream part
  // holds the chain instead of losing the bit that falls off the end.
  assign serial_out_valid_o = (state_reg.buf_cnt != LSS_BUF_EMPTY);
  assign serial_out_pin_o = state_reg.buf_bits[0];
  assign serial_ready_o = (state_reg.buf_cnt != 2'(LSS_BUF_DEPTH));
  assign shift_en = serial_valid_i && serial_ready_o;

  always_comb begin
    logic pop;
    pop = serial_out_valid_o && serial_out_ready_i;
    state_next = state_reg;
    if (pop) begin
      state_next.buf_bits = {1'b0, state_reg.buf_bits[1]};
      state_next.buf_cnt = state_reg.buf_cnt - 2'h1;
    end
    if (shift_en) begin
      // Newest bit enters stage 0; stage 15 leaves toward the cascade
      state_next.shift = {state_reg.shift[LSS_CHANNELS-2:0], serial_in_pin_i};
      state_next.buf_bits[state_next.buf_cnt[0]] = state_reg.shift[LSS_LAST_STAGE];
      state_next.buf_cnt = state_next.buf_cnt + 2'h1;
    end
  end

  // Rising edge only, so the falling edge leaves the chain alone
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '{shift: LSS_SHIFT_RESET, buf_cnt: LSS_BUF_EMPTY, buf_bits: 2'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Transparent latch on the load level, no clock involved
  always_latch begin
    if (latch_load_strobe_i) begin
      latch_q <= state_reg.shift;
    end
  end // Holds otherwise

  // Blank is level-driven; high forces every sink off, one gate per channel
  for (genvar ch = 0; ch < LSS_CHANNELS; ch++) begin : g_sink
    assign sink_channel_n_o[ch] = output_blank_n_i ? 1'b0 : latch_q[ch];
    chan_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!output_blank_n_i && latch_q[ch]) |-> sink_channel_n_o[ch])
      else $error("set latch bit left channel off");
  end

  // Helper nets for the checks only; the datapath never reads them
  logic pop_en;
  logic push_only;
  logic pop_only;
  assign pop_en = serial_out_valid_o && serial_out_ready_i;
  assign push_only = shift_en && !pop_en;
  assign pop_only = pop_en && !shift_en;

  // Step one of the cascade walk: a bit enters an empty buffer while
  // the downstream part stalls, so the head must wait for it
  sequence take_into_empty_s;
    shift_en && (state_reg.buf_cnt == LSS_BUF_EMPTY) && !serial_out_ready_i;
  endsequence

  // Step two: one more bit taken straight after, still stalled
  sequence take_behind_s;
    shift_en && !serial_out_ready_i;
  endsequence

  // Both entries hold bits the receiver has not yet taken
  sequence buffer_full_s;
    state_reg.buf_cnt == 2'(LSS_BUF_DEPTH);
  endsequence

  // An offer that the full buffer turns away
  sequence refused_offer_s;
    serial_valid_i && !serial_ready_o;
  endsequence

  property shift_in_p;
    @(posedge clk_i) disable iff (!rst_n_i)
      shift_en |=> state_reg.shift[0] == $past(serial_in_pin_i);
  endproperty
  shift_entry_a: assert property (shift_in_p)
    else $error("stage 0 missed input");

  shift_move_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shift_en |=> state_reg.shift[15:1] == $past(state_reg.shift[14:0]))
    else $error("chain did not advance");

  shift_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !shift_en |=> $stable(state_reg.shift))
    else $error("chain moved without shift");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!latch_load_strobe_i && $past(!latch_load_strobe_i)) |-> $stable(latch_q))
    else $error("latch changed while closed");

  latch_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    latch_load_strobe_i |-> latch_q == state_reg.shift)
    else $error("open latch not following");

  blank_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    output_blank_n_i |-> sink_channel_n_o == LSS_CHANNELS_OFF)
    else $error("channels on while blanked");

  chan_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !output_blank_n_i |-> sink_channel_n_o == latch_q)
    else $error("channel differs from latch");

  cascade_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (shift_en && state_reg.buf_cnt == LSS_BUF_EMPTY)
      |=> serial_out_valid_o && serial_out_pin_o == $past(state_reg.shift[15]))
    else $error("cascade bit wrong");

  // Older bit leaves first even when both entries fill under a stall
  property cascade_order_p;
    @(posedge clk_i) disable iff (!rst_n_i)
      take_into_empty_s ##1 take_behind_s
        |=> serial_out_pin_o == $past(state_reg.shift[15], 2);
  endproperty
  cascade_order_a: assert property (cascade_order_p)
    else $error("cascade bits out of order");

  // A full buffer must refuse, or the stage 15 bit would be lost
  full_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    buffer_full_s |-> !serial_ready_o)
    else $error("full buffer still ready");

  // Room left means the next bit is welcome
  room_ready_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg.buf_cnt != 2'(LSS_BUF_DEPTH)) |-> serial_ready_o)
    else $error("ready low with room left");

  // A refused offer leaves the chain untouched
  refused_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    refused_offer_s |=> $stable(state_reg.shift))
    else $error("refused bit still shifted");

  // Stalled head keeps its bit until the receiver takes it
  stall_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (serial_out_valid_o && !serial_out_ready_i)
      |=> serial_out_valid_o && $stable(serial_out_pin_o))
    else $error("stalled cascade bit changed");

  // Occupancy moves by one per push or pop, and not at all for both
  push_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    push_only |=> state_reg.buf_cnt == $past(state_reg.buf_cnt) + 2'h1)
    else $error("push did not add an entry");

  pop_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pop_only |=> state_reg.buf_cnt == $past(state_reg.buf_cnt) - 2'h1)
    else $error("pop did not free an entry");

  pass_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (shift_en && pop_en) |=> $stable(state_reg.buf_cnt))
    else $error("push with pop changed occupancy");

  buf_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg.buf_cnt <= 2'(LSS_BUF_DEPTH))
    else $error("buffer count beyond depth");

  // An empty buffer offers nothing downstream
  empty_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg.buf_cnt == LSS_BUF_EMPTY) |-> !serial_out_valid_o)
    else $error("valid with empty buffer");

  // Second entry moves to the head when the first is taken
  drain_next_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pop_only && state_reg.buf_cnt == 2'(LSS_BUF_DEPTH))
      |=> serial_out_valid_o && serial_out_pin_o == $past(state_reg.buf_bits[1]))
    else $error("second entry not promoted");

  // No disable here, so the check watches reset itself
  reset_clear_a: assert property (@(posedge clk_i)
    !rst_n_i |=> (state_reg.shift == LSS_SHIFT_RESET) && !serial_out_valid_o)
    else $error("reset left state behind");

  // Blank beats an open latch: both are levels, no edge ordering
  blank_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (output_blank_n_i && latch_load_strobe_i) |-> sink_channel_n_o == LSS_CHANNELS_OFF)
    else $error("open latch lit blanked channels");
endmodule : lss_core

// ==== tb/lss_cascade_sink.sv ====
// Cascade receiver that takes bits at full or half rate
`timescale 1ns/1ns
module lss_cascade_sink (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic bit_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic [15:0] word_o
);
  logic phase_reg = 1'b0;
  logic [15:0] word_reg = 16'h0000;
  assign word_o = word_reg;
  // Half rate makes the two-entry buffer fill and refuse bits
  always @(negedge clk_i) phase_reg <= ~phase_reg;
  assign ready_o = ~slow_i | phase_reg;
  always @(posedge clk_i) if (valid_i && ready_o) word_reg <= {word_reg[14:0], bit_i};
endmodule : lss_cascade_sink

// ==== tb/tb_lss_core.sv ====
// Bench for the LED sink shift and latch core
`timescale 1ns/1ns
module tb_lss_core;
  import lss_pkg::*;
  logic clk_i = 0, rst_n_i = 0, din = 0, vld = 0, le = 0, oe_n = 1, slow = 0;
  logic rdy, serial_out_pin, sdo_v, ordy, full = 0;
  logic [15:0] ch, word;
  int err_count = 0, n_tests = 0;
  lss_core u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_in_pin_i(din),
    .serial_valid_i(vld), .serial_ready_o(rdy), .latch_load_strobe_i(le),
    .output_blank_n_i(oe_n), .sink_channel_n_o(ch), .serial_out_pin_o(serial_out_pin),
    .serial_out_valid_o(sdo_v), .serial_out_ready_i(ordy));
  lss_cascade_sink u_sink (.clk_i(clk_i), .slow_i(slow), .bit_i(serial_out_pin),
    .valid_i(sdo_v), .ready_o(ordy), .word_o(word));
  always @(negedge clk_i) if (rst_n_i && !rdy) full = 1;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Sends bit 15 first, so bit 0 ends up as the newest stage
  task sh(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk_i); din = v[i]; vld = 1;
      while (!rdy) @(negedge clk_i);
    end
    @(negedge clk_i); vld = 0;
  endtask : sh
  task t_latch;
    sh(16'hA5C3);
    #1 chk(ch, 16'h0000);
    @(negedge clk_i); le = 1;
    #1 chk(ch, 16'hA5C3);
    @(negedge clk_i); oe_n = 1;
    #1 chk(ch, 16'h0000);
    @(negedge clk_i); oe_n = 0; le = 0;
    #1 chk(ch, 16'hA5C3);
  endtask : t_latch
  task t_cascade;
    @(negedge clk_i); slow = 1;
    sh(16'h0F0F);
    #1 chk(ch, 16'hA5C3);
    chk({15'h0000, full}, 16'h0001);
    @(negedge clk_i); slow = 0;
    repeat (4) @(negedge clk_i);
    chk(word, 16'hA5C3);
  endtask : t_cascade
  task end_of_test;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial forever #2 clk_i = ~clk_i;
  initial begin
    #4000 err_count++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1; le = 1;
    @(negedge clk_i); le = 0; oe_n = 0;
    t_latch();
    t_cascade();
    end_of_test();
  end
endmodule : tb_lss_core
